// File: rtl/ptx_byte_framing.v
/*
  Transmit data path of a dibit phase-shift modem: double-buffered byte,
  optional start/parity/stop framing, scrambler with lock-up guard, dibit
  to phase-step mapping, and the modulator control outputs.
  Assumes register writes arrive on the same clock as a one-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptx_defines.vh"

// Behaviour
// - Transmit byte double buffered, eight bit times
// - Four dibits sent, least significant first
// - Dibit selects phase step per table
// - Left dibit bit enters modulator first
// - Framing select picks plain or framed characters
// - Framed character opens with one zero
// - Stop field sets minimum stop bits
// - Receiver ignores stop count
// - Parity enable appends one parity bit
// - Parity sense one odd, zero even
// - Length bit selects seven data bits
// - Inverted driver enabled by bit six
// - Sixty-four output ones invert next input
// - Scrambler enable routes data through scrambler
// - Equaliser level field, zero powers down
// - Modulator enable, else bias and no flags
// - Band select low or high channel
// - Ready flag rise raises masked interrupt
// - Underflow flag rise raises masked interrupt
module ptx_byte_framing #(
  parameter [15:0] BIT_CYCLES = `PTX_BIT_CYCLES
) (
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       wr_strobe_in,
  input  wire [7:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  input  wire       flags_read_in,
  input  wire       ready_mask_in,
  input  wire       underflow_mask_in,
  output reg        tx_ready_flag_out,
  output reg        tx_underflow_flag_out,
  output reg        irq_out,
  output reg  [1:0] dibit_out,
  output reg  [1:0] phase_step_out,
  output reg        symbol_strobe_out,
  output reg        modulator_on_out,
  output reg        bias_level_out,
  output reg        band_select_out,
  output reg  [1:0] eq_level_out,
  output reg        eq_powersave_out,
  output reg        inverted_driver_on_out
);

  reg  [7:0]  hold_byte;
  reg         hold_full;
  reg  [7:0]  framing;
  reg  [7:0]  mod_mode;
  reg  [15:0] bit_timer;
  reg  [11:0] shifter;
  reg  [3:0]  shift_len;
  reg  [16:0] scr_state;
  reg  [6:0]  ones_run;
  reg         half_dibit;
  reg         first_bit;

  wire wr_byte  = wr_strobe_in && (wr_addr_in == `PTX_ADDR_TRANSMIT_BYTE);
  wire wr_frame = wr_strobe_in && (wr_addr_in == `PTX_ADDR_CHARACTER_FRAMING);
  wire wr_mode  = wr_strobe_in && (wr_addr_in == `PTX_ADDR_TRANSMIT_MOD_MODE);

  wire enabled  = mod_mode[`PTX_MOD_MODULATOR_ON];
  wire async    = framing[`PTX_FRM_FRAMING_SELECT];
  wire bit_tick = enabled && (bit_timer == BIT_CYCLES - 16'h0001);
  wire need_load = bit_tick && (shift_len == 4'h0);

  // Number of stop bits for the two-bit stop field; a transmit minimum only
  function [3:0] stop_count;
    input [1:0] code;
    begin
      case (code)
        2'b00:   stop_count = 4'h0;
        2'b11:   stop_count = 4'h2;
        default: stop_count = 4'h1;
      endcase
    end
  endfunction

  // Phase step in quarter turns for a dibit
  function [1:0] phase_of;
    input [1:0] d;
    begin
      case (d)
        2'b00:   phase_of = 2'b01;
        2'b01:   phase_of = 2'b00;
        2'b11:   phase_of = 2'b11;
        default: phase_of = 2'b10;
      endcase
    end
  endfunction

  // Next character, sent from bit 0 upward
  reg  [11:0] next_frame;
  reg  [3:0]  next_len;
  reg  [3:0]  nd;
  reg         par;
  integer     i;
  always @* begin
    next_frame = 12'hFFF;
    next_len   = 4'h0;
    nd         = 4'h0;
    par        = 1'b0;
    if (!async) begin
      // Dibit pairs low end first, left bit of each pair leading
      next_frame = {4'hF, hold_byte[6], hold_byte[7], hold_byte[4], hold_byte[5],
                    hold_byte[2], hold_byte[3], hold_byte[0], hold_byte[1]};
      next_len   = 4'h8;
    end else begin
      nd = framing[`PTX_FRM_SEVEN_BITS] ? 4'h7 : 4'h8;
      next_frame[0] = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        if (i < nd) begin
          next_frame[i + 1] = hold_byte[i];
          par = par ^ hold_byte[i];
        end
      end
      par = par ^ framing[`PTX_FRM_PARITY_ODD];
      if (framing[`PTX_FRM_PARITY_ENABLE]) begin
        next_frame[nd + 4'h1] = par;
      end
      next_len = 4'h1 + nd + {3'b000, framing[`PTX_FRM_PARITY_ENABLE]}
               + stop_count(framing[`PTX_FRM_STOP_HI:`PTX_FRM_STOP_LO]);
    end
  end

  // Bit leaving the framer this tick
  wire raw_bit = need_load ? (hold_full ? next_frame[0] : 1'b1) : shifter[0];

  // Scrambler with lock-up guard
  wire guard_hit = mod_mode[`PTX_MOD_LOCKUP_GUARD] && (ones_run == `PTX_LOCKUP_RUN);
  wire scr_in    = raw_bit ^ guard_hit;
  wire scr_out   = scr_in ^ scr_state[`PTX_SCR_TAP_A] ^ scr_state[`PTX_SCR_TAP_B];
  wire line_bit  = mod_mode[`PTX_MOD_SCRAMBLER_ON] ? scr_out : raw_bit;

  // Registers and holding buffer
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_byte <= `PTX_RST_TRANSMIT_BYTE;
      framing   <= `PTX_RST_CHARACTER_FRAMING;
      mod_mode  <= `PTX_RST_TRANSMIT_MOD_MODE;
      hold_full <= 1'b0;
    end else begin
      if (wr_frame) begin
        framing <= wr_data_in;
      end
      if (wr_mode) begin
        mod_mode <= wr_data_in;
      end
      if (wr_byte) begin
        hold_byte <= wr_data_in;
      end
      // A write in the load cycle refills the buffer just emptied
      if (wr_byte) begin
        hold_full <= 1'b1;
      end else if (need_load) begin
        hold_full <= 1'b0;
      end
    end
  end

  // Bit timing, framer and scrambler
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_timer  <= 16'h0000;
      shifter    <= 12'hFFF;
      shift_len  <= 4'h0;
      scr_state  <= 17'h0_0000;
      ones_run   <= 7'h00;
      half_dibit <= 1'b0;
      first_bit  <= 1'b0;
    end else if (!enabled) begin
      // Disabled path idles so a later enable starts on a clean dibit
      bit_timer  <= 16'h0000;
      shifter    <= 12'hFFF;
      shift_len  <= 4'h0;
      half_dibit <= 1'b0;
    end else begin
      bit_timer <= bit_tick ? 16'h0000 : bit_timer + 16'h0001;
      if (bit_tick) begin
        if (need_load) begin
          if (hold_full) begin
            shifter   <= {1'b1, next_frame[11:1]};
            shift_len <= next_len - 4'h1;
          end else begin
            // Underrun sends marks: a byte of ones, or one idle mark when framed
            shifter   <= 12'hFFF;
            shift_len <= async ? 4'h0 : 4'h7;
          end
        end else begin
          shifter   <= {1'b1, shifter[11:1]};
          shift_len <= shift_len - 4'h1;
        end
        scr_state <= {scr_state[15:0], scr_out};
        if (guard_hit || !scr_out) begin
          ones_run <= 7'h00;
        end else begin
          ones_run <= ones_run + 7'h01;
        end
        half_dibit <= ~half_dibit;
        first_bit  <= line_bit;
      end
    end
  end

  // Dibit output and flags
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dibit_out             <= 2'b00;
      phase_step_out        <= 2'b00;
      symbol_strobe_out     <= 1'b0;
      tx_ready_flag_out     <= 1'b0;
      tx_underflow_flag_out <= 1'b0;
      irq_out               <= 1'b0;
    end else begin
      symbol_strobe_out <= bit_tick && half_dibit;
      if (bit_tick && half_dibit) begin
        dibit_out      <= {first_bit, line_bit};
        phase_step_out <= phase_of({first_bit, line_bit});
      end
      // Set wins over clear; flags only set while the modulator is on, but a read clears both at any time and a byte write clears the ready flag
      if (need_load && hold_full) begin
        tx_ready_flag_out <= 1'b1;
      end else if (flags_read_in || wr_byte) begin
        tx_ready_flag_out <= 1'b0;
      end
      if (need_load && !hold_full) begin
        tx_underflow_flag_out <= 1'b1;
      end else if (flags_read_in) begin
        tx_underflow_flag_out <= 1'b0;
      end
      if ((need_load && hold_full && !tx_ready_flag_out && ready_mask_in) ||
          (need_load && !hold_full && !tx_underflow_flag_out && underflow_mask_in)) begin
        irq_out <= 1'b1;
      end else if (flags_read_in) begin
        irq_out <= 1'b0;
      end
    end
  end

  // Modulator control outputs
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      modulator_on_out       <= 1'b0;
      bias_level_out         <= 1'b1;
      band_select_out        <= 1'b0;
      eq_level_out           <= 2'b00;
      eq_powersave_out       <= 1'b1;
      inverted_driver_on_out <= 1'b0;
    end else begin
      modulator_on_out       <= enabled;
      bias_level_out         <= ~enabled;
      band_select_out        <= mod_mode[`PTX_MOD_BAND_SELECT];
      eq_level_out           <= mod_mode[`PTX_MOD_EQ_LEVEL_HI:`PTX_MOD_EQ_LEVEL_LO];
      eq_powersave_out       <= (mod_mode[`PTX_MOD_EQ_LEVEL_HI:`PTX_MOD_EQ_LEVEL_LO] == 2'b00);
      inverted_driver_on_out <= mod_mode[`PTX_MOD_INVERTED_DRIVER_ON];
    end
  end

endmodule // ptx_byte_framing
`default_nettype wire

// File: shared/ptx_defines.vh
/*
  Constants for the transmit byte framing block: register offsets, field
  positions, reset values and bit timing.
  Assumes it is included by bare name from the design file.
*/
`ifndef PTX_DEFINES_VH
`define PTX_DEFINES_VH

// Register offsets on the serial control port
`define PTX_ADDR_TRANSMIT_BYTE      8'hE3
`define PTX_ADDR_CHARACTER_FRAMING  8'hE4
`define PTX_ADDR_TRANSMIT_MOD_MODE  8'hE7

// Reset values
`define PTX_RST_TRANSMIT_BYTE       8'h00
`define PTX_RST_CHARACTER_FRAMING   8'h00
`define PTX_RST_TRANSMIT_MOD_MODE   8'h00

// Character framing fields
`define PTX_FRM_FRAMING_SELECT      5
`define PTX_FRM_STOP_HI             4
`define PTX_FRM_STOP_LO             3
`define PTX_FRM_PARITY_ENABLE       2
`define PTX_FRM_PARITY_ODD          1
`define PTX_FRM_SEVEN_BITS          0

// Transmit modulator mode fields
`define PTX_MOD_INVERTED_DRIVER_ON  6
`define PTX_MOD_LOCKUP_GUARD        5
`define PTX_MOD_SCRAMBLER_ON        4
`define PTX_MOD_EQ_LEVEL_HI         3
`define PTX_MOD_EQ_LEVEL_LO         2
`define PTX_MOD_MODULATOR_ON        1
`define PTX_MOD_BAND_SELECT         0

// Scrambler taps and lock-up run length
`define PTX_SCR_LEN                 17
`define PTX_SCR_TAP_A               13
`define PTX_SCR_TAP_B               16
`define PTX_LOCKUP_RUN              7'h40

// Timing
// Clocks per bit: 25 MHz over 1200 bps, sized for the 16-bit timer
`define PTX_BIT_CYCLES              16'h5161

`endif

// File: tb/ptx_byte_framing_tb_top.sv
/*
  Bench for the transmit framing block: register writes, line bits, flags.
  Assumes the design runs with a four-clock bit time.
*/
`timescale 1ns/1ps
`default_nettype none
module ptx_byte_framing_tb_top;
  logic        clk_in = 0, resetn_in = 0, wr_strobe_in = 0, flags_read_in = 0;
  logic        ready_mask_in = 0, underflow_mask_in = 0;
  logic [7:0]  wr_addr_in = 8'h00, wr_data_in = 8'h00;
  wire  [1:0]  dibit_out, phase_step_out, eq_level_out;
  wire         tx_ready_flag_out, tx_underflow_flag_out, irq_out, symbol_strobe_out;
  wire         modulator_on_out, bias_level_out, band_select_out, eq_powersave_out, inverted_driver_on_out;
  wire  [31:0] line_bits;
  wire  [7:0]  line_plain;
  int          num_errors = 0, total_checks = 0;
  logic [7:0]  fcfg [2] = '{8'h3f, 8'h26};
  logic [7:0]  fbyte [2] = '{8'h41, 8'h80};
  logic [11:0] fexp [2] = '{12'h041f, 12'h000b};
  always #20 clk_in = ~clk_in;
  ptx_byte_framing #(.BIT_CYCLES(16'h0004)) DUT (.clk_in, .resetn_in, .wr_strobe_in, .wr_addr_in,
    .wr_data_in, .flags_read_in, .ready_mask_in, .underflow_mask_in, .tx_ready_flag_out,
    .tx_underflow_flag_out, .irq_out, .dibit_out, .phase_step_out, .symbol_strobe_out,
    .modulator_on_out, .bias_level_out, .band_select_out, .eq_level_out, .eq_powersave_out,
    .inverted_driver_on_out);
  ptx_line_partner u_line (.clk_in, .symbol_strobe_in(symbol_strobe_out), .dibit_in(dibit_out),
    .bits_out(line_bits), .plain_out(line_plain));
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_strobe_in = 1;
    wr_addr_in = a;
    wr_data_in = d;
    @(negedge clk_in);
    wr_strobe_in = 0;
  endtask
  // Bounded wait for n symbols on the line
  task automatic wait_sym(input int n);
    int t;
    t = 0;
    while (n > 0 && t < 2000) begin
      @(negedge clk_in);
      t++;
      if (symbol_strobe_out === 1'b1) n--;
    end
    // Partner takes the dibit one edge after the strobe
    @(negedge clk_in);
    if (n > 0) begin
      num_errors++;
      close_out();
    end
  endtask
  initial begin
    repeat (20) @(negedge clk_in);
    resetn_in = 1;
    chk("bias", 1, bias_level_out);
    chk("eq_ps", 1, eq_powersave_out);
    chk("mod_on", 0, modulator_on_out);
    for (int i = 0; i < 4; i++) begin
      wr(8'he7, {1'b0, i[0], 2'b00, i[1:0], 1'b0, i[1]});
      // Outputs follow the register one edge later
      @(negedge clk_in);
      chk("eq", i[1:0], eq_level_out);
      chk("inv", i[0], inverted_driver_on_out);
      chk("band", i[1], band_select_out);
    end
    wr(8'he5, 8'h00);
    chk("unmapped", 3, eq_level_out);
    ready_mask_in = 1;
    underflow_mask_in = 1;
    wr(8'he4, 8'h00);
    wr(8'he7, 8'h02);
    wr(8'he3, 8'h1b);
    wait_sym(1);
    chk("ready", 1, tx_ready_flag_out);
    chk("irq", 1, irq_out);
    flags_read_in = 1;
    @(negedge clk_in);
    flags_read_in = 0;
    wr(8'he3, 8'hc6);
    wait_sym(7);
    chk("plain", 16'he493, line_bits[15:0]);
    // Clear the ready interrupt so the underflow one is seen on its own
    flags_read_in = 1;
    @(negedge clk_in);
    flags_read_in = 0;
    wait_sym(1);
    chk("underflow", 1, tx_underflow_flag_out);
    chk("irq_u", 1, irq_out);
    for (int k = 0; k < 2; k++) begin
      wr(8'he7, 8'h00);
      wr(8'he4, fcfg[k]);
      wr(8'he7, 8'h02);
      wr(8'he3, fbyte[k]);
      wait_sym(6);
      chk("framed", fexp[k], line_bits[11:0]);
    end
    // Scrambled plain bytes; the partner needs 17 scrambled bits of history
    wr(8'he7, 8'h00);
    wr(8'he4, 8'h00);
    wr(8'he7, 8'h12);
    for (int k = 0; k < 4; k++) begin
      wr(8'he3, 8'h1b);
      wait_sym(k == 0 ? 1 : (k == 3 ? 7 : 4));
    end
    chk("scrambled", 8'he4, line_plain);
    close_out();
  end
endmodule // ptx_byte_framing_tb_top
bind ptx_byte_framing ptx_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.clk_in, .resetn_in, .wr_strobe_in,
  .wr_addr_in, .wr_data_in, .ready_mask_in, .underflow_mask_in, .tx_ready_flag_out, .tx_underflow_flag_out,
  .irq_out, .dibit_out, .phase_step_out, .symbol_strobe_out, .modulator_on_out, .bias_level_out,
  .band_select_out, .eq_level_out, .eq_powersave_out, .inverted_driver_on_out);
`default_nettype wire

// File: tb/ptx_checker_assertions.sv
/*
  Port checker for the transmit framing block.
  Assumes it is bound onto the top module by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ptx_checker #(
  parameter [15:0] BIT_CYCLES = 16'h0004
) (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       wr_strobe_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       ready_mask_in,
  input wire logic       underflow_mask_in,
  input wire logic       tx_ready_flag_out,
  input wire logic       tx_underflow_flag_out,
  input wire logic       irq_out,
  input wire logic [1:0] dibit_out,
  input wire logic [1:0] phase_step_out,
  input wire logic       symbol_strobe_out,
  input wire logic       modulator_on_out,
  input wire logic       bias_level_out,
  input wire logic       band_select_out,
  input wire logic [1:0] eq_level_out,
  input wire logic       eq_powersave_out,
  input wire logic       inverted_driver_on_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire mode_wr;
  assign mode_wr = wr_strobe_in && wr_addr_in == 8'he7;
  logic [15:0] gap_cnt;
  // Cycles since the last symbol; cleared while the modulator is off
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) gap_cnt <= 16'h0000;
    else if (!modulator_on_out) gap_cnt <= 16'h0000;
    else if (symbol_strobe_out) gap_cnt <= 16'h0001;
    else if (gap_cnt != 16'h0000) gap_cnt <= gap_cnt + 16'h0001;
  end
  property p_gap; symbol_strobe_out && gap_cnt != 16'h0000 |-> gap_cnt == 2 * BIT_CYCLES; endproperty
  a_gap: assert property (p_gap) else $error("symbol spacing wrong");
  property p_phase; symbol_strobe_out |-> phase_step_out == {dibit_out[1], ~^dibit_out}; endproperty
  a_phase: assert property (p_phase) else $error("phase step wrong");
  property p_bias; bias_level_out == !modulator_on_out; endproperty
  a_bias: assert property (p_bias) else $error("bias level wrong");
  property p_eq_ps; eq_powersave_out == (eq_level_out == 2'b00); endproperty
  a_eq_ps: assert property (p_eq_ps) else $error("equaliser powersave wrong");
  // Register takes the write, the output flop follows one edge later
  property p_mode; mode_wr |=> ##1 modulator_on_out == $past(wr_data_in[1], 2)
    && band_select_out == $past(wr_data_in[0], 2); endproperty
  a_mode: assert property (p_mode) else $error("enable or band wrong");
  property p_inv; mode_wr |=> ##1 inverted_driver_on_out == $past(wr_data_in[6], 2); endproperty
  a_inv: assert property (p_inv) else $error("inverted driver wrong");
  property p_eq; mode_wr |=> ##1 eq_level_out == $past(wr_data_in[3:2], 2); endproperty
  a_eq: assert property (p_eq) else $error("equaliser level wrong");
  // Three quiet cycles so a tick already in flight may finish
  property p_quiet; !modulator_on_out [*3] |-> !symbol_strobe_out && !$rose(tx_ready_flag_out)
    && !$rose(tx_underflow_flag_out); endproperty
  a_quiet: assert property (p_quiet) else $error("activity while disabled");
  property p_irq_rdy; $rose(tx_ready_flag_out) && ready_mask_in |-> ##[0:1] irq_out; endproperty
  a_irq_rdy: assert property (p_irq_rdy) else $error("ready interrupt missing");
  property p_irq_und; $rose(tx_underflow_flag_out) && underflow_mask_in |-> ##[0:1] irq_out; endproperty
  a_irq_und: assert property (p_irq_und) else $error("underflow interrupt missing");
  c_sym: cover property (symbol_strobe_out);
  c_und: cover property ($rose(tx_underflow_flag_out));
  c_irq: cover property ($rose(irq_out));
endmodule // ptx_checker
`default_nettype wire

// File: tb/ptx_line_partner.sv
/*
  Far-end line model: gathers transmitted bits in line order.
  Assumes one strobe from the transmitter for each dibit.
*/
`timescale 1ns/1ps
`default_nettype none
module ptx_line_partner (
  input  wire logic        clk_in,
  input  wire logic        symbol_strobe_in,
  input  wire logic [1:0]  dibit_in,
  output var  logic [31:0] bits_out,
  output var  logic [7:0]  plain_out
);
  logic [31:0] hist = 32'h0000_0000;
  // Left bit is first on the line; any stop count is taken
  always @(posedge clk_in)
    if (symbol_strobe_in) hist <= {hist[29:0], dibit_in};
  assign bits_out = hist;
  // Self-synchronising descrambler on the newest byte, taps 14 and 17 back
  assign plain_out = hist[7:0] ^ hist[21:14] ^ hist[24:17];
endmodule // ptx_line_partner
`default_nettype wire
